// [rtl/mac_pkg.sv]
/*
 * constants for the algorithm control register bank: offsets, field
 * positions, reset values and cycle counts.
 * assumes a word-wide register port from the serial management front end.
 */
package mac_pkg;

    // register offsets (word address as printed)
    localparam logic [7:0] OFS_CTRL_WORD   = 8'hEA;
    localparam logic [7:0] OFS_DEBUG_ONE   = 8'hEC;
    localparam logic [7:0] OFS_DEBUG_TWO   = 8'hEE;
    localparam logic [7:0] OFS_CUR_GAINS   = 8'hF0;
    localparam logic [7:0] OFS_SPD_GAINS   = 8'hF2;
    localparam logic [7:0] OFS_MON_ONE     = 8'hF4;
    localparam logic [7:0] OFS_MON_TWO     = 8'hF6;

    // control word field positions
    localparam int BIT_COMMIT      = 31;
    localparam int BIT_RELOAD      = 30;
    localparam int BIT_FLT_CLR     = 29;
    localparam int BIT_RETRY_CLR   = 28;
    localparam int ANGLE_HI        = 19;
    localparam int ANGLE_LO        = 11;
    localparam int BIT_KICK        = 10;

    localparam logic [31:0] CTRL_RESET   = 32'h00000000;
    localparam logic [31:0] WORD_RESET   = 32'h00000000;
    localparam logic [8:0]  ANGLE_WRAP   = 9'h168;

    // default host kick interval in clock cycles
    localparam logic [31:0] KICK_INTERVAL_DEF = 32'h000F4240;

    typedef enum logic [1:0] {
        NV_IDLE,
        NV_COMMIT,
        NV_RELOAD
    } mac_nv_state_t;

endpackage

// [rtl/mac_algo_control_regs.sv]
/*
 * algorithm control register bank: control word with nv-storage commands,
 * fault clear pulses, forced-align angle and host watchdog kick.
 * assumes a synchronous register port driven by the serial front end and an
 * nv-storage engine answering with a done pulse.
 */
`timescale 1ns/1ns
module mac_algo_control_regs #(
    parameter logic [31:0] KICK_INTERVAL = mac_pkg::KICK_INTERVAL_DEF
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // register port
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    output logic      [31:0] regRdData,
    output logic             regRdValid,
    // nv-storage engine
    output logic             configCommitReq,
    output logic             configReloadReq,
    input  wire logic        nvDone,
    // fault logic
    output logic             faultClearCmd,
    output logic             retryCounterClearCmd,
    // alignment
    input  wire logic        forcedAlignEn,
    output logic      [8:0]  alignAngle,
    // host watchdog
    input  wire logic        hostWdtEnable,
    output logic             hostWdtFault,
    // algorithm side inputs for read-only gains
    input  wire logic [31:0] currentLoopGains,
    input  wire logic [31:0] speedLoopGains
);

    ////////////////////////////////////////////////////////////////////////
    logic               ctrlWr;
    logic        [31:0] ctrlWord_q;
    logic        [31:0] debugOne_q;
    logic        [31:0] debugTwo_q;
    logic        [31:0] monOne_q;
    logic        [31:0] monTwo_q;
    logic        [31:0] kickCnt_q;
    logic               kickSeen;
    mac_pkg::mac_nv_state_t nvState_q;
    logic               nvBusy;
    logic        [8:0]  rawAngle;
    logic        [8:0]  wrapAngle;
    logic        [31:0] ctrlReadView;

    // a word-wide match only; partial offsets inside the word are not decoded
    assign ctrlWr = regWrEn && (regAddr == mac_pkg::OFS_CTRL_WORD);

    // request still pending at the engine this cycle
    assign nvBusy = (nvState_q != mac_pkg::NV_IDLE) && !nvDone;

    ////////////////////////////////////////////////////////////////////////
    // control word: commands and angle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlWord_q <= mac_pkg::CTRL_RESET;
        end else begin
            if (ctrlWr) begin
                ctrlWord_q <= regWrData;
                // write-only pulses are never stored
                ctrlWord_q[mac_pkg::BIT_FLT_CLR]   <= 1'b0;
                ctrlWord_q[mac_pkg::BIT_RETRY_CLR] <= 1'b0;
                // a commit or reload in flight is not dropped by a rewrite
                if (nvBusy) begin
                    ctrlWord_q[mac_pkg::BIT_COMMIT] <= ctrlWord_q[mac_pkg::BIT_COMMIT]
                                                     | regWrData[mac_pkg::BIT_COMMIT];
                    ctrlWord_q[mac_pkg::BIT_RELOAD] <= ctrlWord_q[mac_pkg::BIT_RELOAD]
                                                     | regWrData[mac_pkg::BIT_RELOAD];
                end
            end else begin
                // kick consumed one cycle after it lands
                ctrlWord_q[mac_pkg::BIT_KICK] <= 1'b0;
                if (nvDone && nvState_q == mac_pkg::NV_COMMIT) begin
                    ctrlWord_q[mac_pkg::BIT_COMMIT] <= 1'b0;
                end
                if (nvDone && nvState_q == mac_pkg::NV_RELOAD) begin
                    ctrlWord_q[mac_pkg::BIT_RELOAD] <= 1'b0;
                end
            end
        end
    end

    assign faultClearCmd        = ctrlWr && regWrData[mac_pkg::BIT_FLT_CLR];
    assign retryCounterClearCmd = ctrlWr && regWrData[mac_pkg::BIT_RETRY_CLR];

    ////////////////////////////////////////////////////////////////////////
    // nv-storage sequencing; commit has priority if both are set
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nvState_q <= mac_pkg::NV_IDLE;
        end else begin
            case (nvState_q)
                mac_pkg::NV_IDLE: begin
                    if (ctrlWord_q[mac_pkg::BIT_COMMIT]) begin
                        nvState_q <= mac_pkg::NV_COMMIT;
                    end else if (ctrlWord_q[mac_pkg::BIT_RELOAD]) begin
                        nvState_q <= mac_pkg::NV_RELOAD;
                    end
                end
                mac_pkg::NV_COMMIT, mac_pkg::NV_RELOAD: begin
                    // one request at a time; a queued reload starts after done
                    if (nvDone) begin
                        nvState_q <= mac_pkg::NV_IDLE;
                    end
                end
                default: nvState_q <= mac_pkg::NV_IDLE;
            endcase
        end
    end

    // levels straight from state, so the engine sees them without extra delay
    assign configCommitReq = (nvState_q == mac_pkg::NV_COMMIT);
    assign configReloadReq = (nvState_q == mac_pkg::NV_RELOAD);

    ////////////////////////////////////////////////////////////////////////
    // alignment angle; a 9-bit value exceeds 360 at most once
    assign rawAngle  = ctrlWord_q[mac_pkg::ANGLE_HI:mac_pkg::ANGLE_LO];
    // single subtract is enough: 511 - 360 stays below 360
    assign wrapAngle = (rawAngle >= mac_pkg::ANGLE_WRAP)
                     ? rawAngle - mac_pkg::ANGLE_WRAP
                     : rawAngle;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alignAngle <= 9'h000;
        end else if (forcedAlignEn) begin
            alignAngle <= wrapAngle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host watchdog: fault stays until a fault-clear command
    assign kickSeen = ctrlWord_q[mac_pkg::BIT_KICK];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kickCnt_q    <= 32'h00000000;
            hostWdtFault <= 1'b0;
        end else begin
            if (!hostWdtEnable || kickSeen) begin
                kickCnt_q <= 32'h00000000;
            end else if (kickCnt_q < KICK_INTERVAL) begin
                kickCnt_q <= kickCnt_q + 32'h00000001;
            end
            // set wins over a simultaneous clear
            if (hostWdtEnable && !kickSeen && kickCnt_q >= KICK_INTERVAL - 32'h00000001) begin
                hostWdtFault <= 1'b1;
            end else if (faultClearCmd) begin
                hostWdtFault <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // neighbouring plain registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            debugOne_q <= mac_pkg::WORD_RESET;
            debugTwo_q <= mac_pkg::WORD_RESET;
            monOne_q   <= mac_pkg::WORD_RESET;
            monTwo_q   <= mac_pkg::WORD_RESET;
        end else if (regWrEn) begin
            case (regAddr)
                mac_pkg::OFS_DEBUG_ONE: debugOne_q <= regWrData;
                mac_pkg::OFS_DEBUG_TWO: debugTwo_q <= regWrData;
                mac_pkg::OFS_MON_ONE:   monOne_q   <= regWrData;
                mac_pkg::OFS_MON_TWO:   monTwo_q   <= regWrData;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readable view of the control word: commit, reload, kick only
    assign ctrlReadView = {ctrlWord_q[mac_pkg::BIT_COMMIT],
                           ctrlWord_q[mac_pkg::BIT_RELOAD],
                           19'h00000,
                           ctrlWord_q[mac_pkg::BIT_KICK],
                           10'h000};

    ////////////////////////////////////////////////////////////////////////
    // read path, one cycle latency; write-only fields read zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData  <= 32'h00000000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                case (regAddr)
                    mac_pkg::OFS_CTRL_WORD: regRdData <= ctrlReadView;
                    mac_pkg::OFS_DEBUG_ONE: regRdData <= debugOne_q;
                    mac_pkg::OFS_DEBUG_TWO: regRdData <= debugTwo_q;
                    mac_pkg::OFS_CUR_GAINS: regRdData <= currentLoopGains;
                    mac_pkg::OFS_SPD_GAINS: regRdData <= speedLoopGains;
                    mac_pkg::OFS_MON_ONE:   regRdData <= monOne_q;
                    mac_pkg::OFS_MON_TWO:   regRdData <= monTwo_q;
                    default:                regRdData <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// [sim/mac_nv_model.sv]
/* behavioural nv-storage engine answering the bank's requests.
   assumes requests are levels held until nvDone; lat sets the delay. */
`timescale 1ns/1ns
module mac_nv_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // requests and answer
    input  wire logic       commitReq,
    input  wire logic       reloadReq,
    input  wire logic [3:0] lat,
    output logic            nvDone
);
    logic [3:0] cnt_q;
    // restart per request so a queued reload waits its own delay
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= 4'h0;
            nvDone <= 1'b0;
        end else if ((commitReq || reloadReq) && !nvDone) begin
            nvDone <= (cnt_q == lat);
            cnt_q  <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
        end else begin
            nvDone <= 1'b0;
            cnt_q  <= 4'h0;
        end
    end
endmodule

// [sim/mac_algo_control_regs_monitor.sv]
/* assertions on the control register bank ports.
   assumes one clock domain; bound onto the bank below. */
`timescale 1ns/1ns
module mac_regs_monitor (
    input wire logic        mclk, arst_n, regWrEn, regRdEn, regRdValid, nvDone, forcedAlignEn,
    input wire logic        configCommitReq, configReloadReq, faultClearCmd, retryCounterClearCmd, hostWdtFault,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData, regRdData,
    input wire logic [8:0]  alignAngle
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire ctrlWr = regWrEn && regAddr == mac_pkg::OFS_CTRL_WORD;
    wire nvIdle = !configCommitReq && !configReloadReq;
    sequence sCommitWr; ctrlWr && regWrData[31] && nvIdle; endsequence
    sequence sReloadWr; ctrlWr && regWrData[30] && !regWrData[31] && nvIdle; endsequence
    ////////////////////////////////////////////////////////////
    chk_read_answer: assert property (regRdEn |=> regRdValid) else $error("read unanswered");
    chk_unmapped_zero: assert property (regRdEn && regAddr == 8'h00 |=> regRdData == 32'h0) else $error("rsvd");
    chk_fault_clear: assert property (faultClearCmd == (ctrlWr && regWrData[29])) else $error("clr pulse");
    chk_retry_clear: assert property (retryCounterClearCmd == (ctrlWr && regWrData[28])) else $error("retry");
    chk_commit_start: assert property (sCommitWr |-> ##2 configCommitReq) else $error("commit late");
    chk_commit_hold: assert property (configCommitReq && !nvDone |=> configCommitReq) else $error("commit drop");
    chk_reload_start: assert property (sReloadWr |-> ##2 configReloadReq) else $error("reload late");
    chk_align_hold: assert property (!forcedAlignEn |=> $stable(alignAngle)) else $error("angle moved");
    chk_wdt_sticky: assert property (hostWdtFault && !(ctrlWr && regWrData[29]) |=> hostWdtFault) else $error("wdt");
endmodule
bind mac_algo_control_regs mac_regs_monitor u_mon (.mclk, .arst_n, .regWrEn, .regRdEn, .regRdValid, .nvDone,
    .forcedAlignEn, .configCommitReq, .configReloadReq, .faultClearCmd, .retryCounterClearCmd, .hostWdtFault,
    .regAddr, .regWrData, .regRdData, .alignAngle);

// [sim/test_mac_algo_control_regs.sv]
/* self-checking bench for the control register bank.
   assumes the nv model and the monitor bind are compiled first. */
`timescale 1ns/1ns
module test_mac_algo_control_regs;
    localparam logic [7:0] CW = mac_pkg::OFS_CTRL_WORD;
    logic        mclk = 0, arst_n = 0, regWrEn = 0, regRdEn = 0, forcedAlignEn = 0, hostWdtEnable = 0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, curGains = 32'h1234ABCD, spdGains = 32'h5A5A0F0F;
    logic        regRdValid, configCommitReq, configReloadReq, nvDone, faultClearCmd, retryClr, hostWdtFault;
    logic [8:0]  alignAngle;
    logic [3:0]  nvLat = 4'h6;
    int          n_fail = 0, checks_done = 0, cyc = 0;
    always #5 mclk = ~mclk;
    mac_algo_control_regs #(.KICK_INTERVAL(32'h14)) u_dut (.mclk, .arst_n, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .configCommitReq, .configReloadReq, .nvDone, .faultClearCmd,
        .retryCounterClearCmd(retryClr), .forcedAlignEn, .alignAngle, .hostWdtEnable, .hostWdtFault,
        .currentLoopGains(curGains), .speedLoopGains(spdGains));
    mac_nv_model u_nv (.mclk, .arst_n, .commitReq(configCommitReq), .reloadReq(configReloadReq), .lat(nvLat), .nvDone);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk); regWrEn = 1; regAddr = a; regWrData = d;
        @(negedge mclk); regWrEn = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge mclk); regRdEn = 1; regAddr = a;
        @(negedge mclk); regRdEn = 0;
        chk(regRdValid, 1);
        chk(regRdData, exp);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin n_fail++; wrap_up; end
    end
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(CW, 32'h0);
        rd(8'hEC, 32'h0);
        wr(8'hEC, 32'hA5A5C3C3);
        rd(8'hEC, 32'hA5A5C3C3);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h0);
        wr(8'hF0, 32'h0);
        rd(8'hF0, curGains);
        rd(8'hF2, spdGains);
        wr(8'hF4, 32'h0F0F1234);
        rd(8'hF4, 32'h0F0F1234);
    endtask
    task automatic t_rst;
        @(negedge mclk); arst_n = 0;
        repeat (3) @(negedge mclk);
        chk(alignAngle, 9'h000);
        arst_n = 1;
        rd(8'hEC, 32'h0);
        rd(8'hF4, 32'h0);
    endtask
    task automatic t_nv;
        for (int i = 0; i < 2; i++) begin
            nvLat = i ? 4'h0 : 4'h6;
            wr(CW, i ? 32'h40000000 : 32'h80000000);
            for (int k = 0; k < 5 && (i ? configReloadReq : configCommitReq) !== 1'b1; k++) @(negedge mclk);
            chk(i ? configReloadReq : configCommitReq, 1);
            if (i == 0) rd(CW, 32'h80000000);
            for (int k = 0; k < 20 && (configCommitReq | configReloadReq) !== 1'b0; k++) @(negedge mclk);
            rd(CW, 32'h0);
        end
    endtask
    task automatic t_clear;
        @(negedge mclk); regWrEn = 1; regAddr = CW; regWrData = 32'h30000000;
        #1 chk({faultClearCmd, retryClr}, 2'h3);
        @(negedge mclk); regWrEn = 0;
        #1 chk({faultClearCmd, retryClr}, 2'h0);
        rd(CW, 32'h0);
    endtask
    task automatic t_angle;
        logic [8:0] v[3] = '{9'h190, 9'h168, 9'h167}, e[3] = '{9'h028, 9'h000, 9'h167};
        forcedAlignEn = 1;
        for (int i = 0; i < 3; i++) begin
            wr(CW, {12'h0, v[i], 11'h0});
            repeat (2) @(negedge mclk);
            chk(alignAngle, e[i]);
        end
        forcedAlignEn = 0;
        wr(CW, 32'h00005000);
        repeat (2) @(negedge mclk);
        chk(alignAngle, 9'h167);
    endtask
    task automatic t_wdt;
        hostWdtEnable = 1;
        @(negedge mclk); regWrEn = 1; regAddr = CW; regWrData = 32'h00000400;
        @(negedge mclk); regWrEn = 0; regRdEn = 1;
        @(negedge mclk); regRdEn = 0;
        chk(regRdData, 32'h00000400);
        repeat (4) begin
            wr(CW, 32'h00000400);
            repeat (8) @(negedge mclk);
        end
        chk(hostWdtFault, 0);
        rd(CW, 32'h0);
        repeat (25) @(negedge mclk);
        chk(hostWdtFault, 1);
        hostWdtEnable = 0;
        wr(CW, 32'h20000000);
        chk(hostWdtFault, 0);
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        arst_n = 1;
        t_regs; t_nv; t_clear; t_angle; t_rst; t_wdt;
        wrap_up;
    end
endmodule
